// ===== hdl/rmsl_link.sv
// Half-duplex slave link sequencer, station settings and counters.
// Assumes frame and character engines outside report events
// synchronous to mclk and one-cycle wide.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

module rmsl_link #(
    parameter int MS_CYCLES_P = rmsl_pkg::MS_CYCLES
) (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic                ce,
    input  wire rmsl_pkg::rmsl_bus_t bus,
    output logic [rmsl_pkg::DW-1:0]  reg_rdata,
    input  wire rmsl_pkg::rmsl_txev_t tx_ev,
    input  wire rmsl_pkg::rmsl_rxev_t rx_ev,
    output rmsl_pkg::rmsl_cfg_t      cfg,
    output rmsl_pkg::rmsl_out_t      ctl
);
    import rmsl_pkg::*;

    rmsl_reg_t         r_reg;
    rmsl_reg_t         r_next;
    logic [NCNT-1:0]   inc;
    logic              clr;
    logic              tick;
    logic              hs;
    logic              rx_bad;
    logic              rx_mine;
    logic              rx_dup;
    logic              par_now;
    logic              give_up;

    // ---------------------------------------------
    // Outputs straight from the state register
    // ---------------------------------------------
    assign reg_rdata = r_reg.rdata;
    assign cfg       = r_reg.cfg;
    assign ctl       = r_reg.out;

    // ---------------------------------------------
    // Next-state logic
    // ---------------------------------------------
    always_comb begin
        r_next            = r_reg;
        inc               = '0;
        clr               = 1'b0;
        r_next.out.msg_err = 1'b0;
        r_next.out.msg_ok  = 1'b0;
        r_next.out.rx_ack  = 1'b0;
        r_next.out.rx_exec = 1'b0;

        // Millisecond prescaler
        tick = (r_reg.ms_cnt == MSW'(MS_CYCLES_P - 1));
        if (tick) begin
            r_next.ms_cnt = '0;
        end else begin
            r_next.ms_cnt = r_reg.ms_cnt + MSW'(1);
        end
        hs = (r_reg.cfg.mode != MODE_NONE);
        give_up = (r_reg.tries >= r_reg.retries);

        // Register read, data valid next cycle
        r_next.rdata = '0;
        if (bus.re) begin
            if (bus.addr == ADDR_CFG) begin
                r_next.rdata[CFG_BAUD_LSB +: 3] = r_reg.cfg.baud;
                r_next.rdata[CFG_PAR_LSB +: 2]  = r_reg.cfg.par;
                r_next.rdata[CFG_MODE_LSB +: 2] = r_reg.cfg.mode;
                r_next.rdata[CFG_CRC_BIT]       = r_reg.cfg.crc;
                r_next.rdata[CFG_DUP_BIT]       = r_reg.cfg.dup;
            end else if (bus.addr == ADDR_NODE) begin
                r_next.rdata = {8'h00, r_reg.cfg.node};
            end else if (bus.addr == ADDR_POLL) begin
                r_next.rdata = r_reg.poll;
            end else if (bus.addr == ADDR_OFF) begin
                r_next.rdata = r_reg.off;
            end else if (bus.addr == ADDR_ON) begin
                r_next.rdata = r_reg.on;
            end else if (bus.addr == ADDR_PRE) begin
                r_next.rdata = r_reg.pre;
            end else if (bus.addr == ADDR_RETRY) begin
                r_next.rdata = {8'h00, r_reg.retries};
            end else if (bus.addr == ADDR_STAT) begin
                r_next.rdata = {8'h00, r_reg.tries[3:0],
                                r_reg.out.rts, r_reg.st};
            end else begin
                r_next.rdata = r_reg.cnt[bus.addr[2:0]];
            end
        end

        // Register write
        if (bus.we) begin
            if (bus.addr == ADDR_CFG) begin
                r_next.cfg.baud = bus.wdata[CFG_BAUD_LSB +: 3];
                r_next.cfg.par  = bus.wdata[CFG_PAR_LSB +: 2];
                r_next.cfg.mode = bus.wdata[CFG_MODE_LSB +: 2];
                r_next.cfg.crc  = bus.wdata[CFG_CRC_BIT];
                r_next.cfg.dup  = bus.wdata[CFG_DUP_BIT];
            end else if (bus.addr == ADDR_NODE) begin
                // Broadcast value is not a station address
                if (bus.wdata[7:0] != NODE_BCAST) begin
                    r_next.cfg.node = bus.wdata[7:0];
                end
            end else if (bus.addr == ADDR_POLL) begin
                r_next.poll = bus.wdata;
            end else if (bus.addr == ADDR_OFF) begin
                r_next.off = bus.wdata;
            end else if (bus.addr == ADDR_ON) begin
                r_next.on = bus.wdata;
            end else if (bus.addr == ADDR_PRE) begin
                r_next.pre = bus.wdata;
            end else if (bus.addr == ADDR_RETRY) begin
                r_next.retries = bus.wdata[7:0];
            end else if (bus.addr == ADDR_STAT) begin
                clr = bus.wdata[STAT_CLR_BIT];
            end
        end

        // NAKs counted wherever they arrive
        inc[CNT_NAK] = tx_ev.nak_rx;

        // Transmit sequencer
        case (r_reg.st)
            ST_IDLE: begin
                if (tx_ev.msg_req) begin
                    r_next.st     = ST_POLL;
                    r_next.tries  = '0;
                    r_next.resend = 1'b0;
                    r_next.tmr    = TW'(r_reg.poll) * TW'(STEP_MS);
                    r_next.ms_cnt = '0;
                end
            end
            ST_POLL: begin
                // Queued until this slave is polled again
                if (tx_ev.msg_tmo) begin
                    r_next.st          = ST_IDLE;
                    r_next.out.msg_err = 1'b1;
                end else if (tx_ev.poll_rx) begin
                    r_next.st     = ST_PRE;
                    r_next.tmr    = TW'(r_reg.pre);
                    r_next.ms_cnt = '0;
                end else if (r_reg.poll != '0) begin
                    if (r_reg.tmr == '0) begin
                        r_next.st          = ST_IDLE;
                        r_next.out.msg_err = 1'b1;
                    end else if (tick) begin
                        r_next.tmr = r_reg.tmr - TW'(1);
                    end
                end
            end
            ST_PRE: begin
                if (r_reg.tmr != '0) begin
                    if (tick) begin
                        r_next.tmr = r_reg.tmr - TW'(1);
                    end
                end else if (hs) begin
                    r_next.st      = ST_RON;
                    r_next.out.rts = 1'b1;
                    r_next.tmr     = TW'(r_reg.on) * TW'(STEP_MS);
                    r_next.ms_cnt  = '0;
                end else begin
                    r_next.st = ST_SEND;
                end
            end
            ST_RON: begin
                if (r_reg.tmr != '0) begin
                    if (tick) begin
                        r_next.tmr = r_reg.tmr - TW'(1);
                    end
                end else begin
                    r_next.st = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_ev.tx_done) begin
                    inc[CNT_SENT]  = 1'b1;
                    inc[CNT_RETRY] = r_reg.resend;
                    if (hs) begin
                        r_next.st     = ST_ROFF;
                        r_next.tmr    = TW'(r_reg.off) * TW'(STEP_MS);
                        r_next.ms_cnt = '0;
                    end else begin
                        r_next.st = ST_ACK;
                    end
                end
            end
            ST_ROFF: begin
                if (r_reg.tmr != '0) begin
                    if (tick) begin
                        r_next.tmr = r_reg.tmr - TW'(1);
                    end
                end else begin
                    r_next.st      = ST_ACK;
                    r_next.out.rts = 1'b0;
                end
            end
            ST_ACK: begin
                if (tx_ev.ack_rx) begin
                    r_next.st         = ST_IDLE;
                    r_next.out.msg_ok = 1'b1;
                end else if (tx_ev.nak_rx || tx_ev.ack_tmo ||
                             tx_ev.msg_tmo) begin
                    if (give_up || tx_ev.msg_tmo) begin
                        r_next.st          = ST_IDLE;
                        r_next.out.msg_err = 1'b1;
                        inc[CNT_UNDEL]     = 1'b1;
                    end else begin
                        r_next.st     = ST_PRE;
                        r_next.resend = 1'b1;
                        r_next.tries  = r_reg.tries + 8'h01;
                        r_next.tmr    = TW'(r_reg.pre);
                        r_next.ms_cnt = '0;
                    end
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase

        // With a handshake mode set, characters leave only while clear-to-send is high
        r_next.out.tx_en = (r_next.st == ST_SEND) &&
                           (!hs || tx_ev.cts);

        // Per-character parity check on receive
        par_now = 1'b0;
        if (rx_ev.chr_valid) begin
            if (r_reg.cfg.par == PAR_EVEN) begin
                par_now = ^{rx_ev.chr, rx_ev.chr_par};
            end else if (r_reg.cfg.par == PAR_ODD) begin
                par_now = ~^{rx_ev.chr, rx_ev.chr_par};
            end
        end
        r_next.par_err = r_reg.par_err | par_now;

        // Frame end: check, address, buffer, duplicate
        rx_bad  = !rx_ev.chk_ok || r_reg.par_err || par_now;
        rx_mine = (rx_ev.dst == r_reg.cfg.node) ||
                  (rx_ev.dst == NODE_BCAST);
        rx_dup  = r_reg.have_sig && (rx_ev.sig == r_reg.last_sig);
        if (rx_ev.frm_end) begin
            r_next.par_err = 1'b0;
            if (rx_bad) begin
                inc[CNT_BAD] = 1'b1;
            end else if (!rx_mine) begin
                r_next.par_err = 1'b0;
            end else if (!rx_ev.buf_free) begin
                inc[CNT_NOMEM] = 1'b1;
            end else begin
                inc[CNT_RECV]     = 1'b1;
                inc[CNT_DUP]      = rx_dup;
                r_next.out.rx_ack = 1'b1;
                r_next.out.rx_exec = !(rx_dup && r_reg.cfg.dup);
                r_next.have_sig   = 1'b1;
                r_next.last_sig   = rx_ev.sig;
            end
        end

        // Counters: clear first, then a same-cycle event still counts
        for (int i = 0; i < NCNT; i++) begin
            if (clr) begin
                r_next.cnt[i] = '0;
            end
            if (inc[i] && (r_next.cnt[i] != CNT_MAX)) begin
                r_next.cnt[i] = r_next.cnt[i] + DW'(1);
            end
        end
    end

    // ---------------------------------------------
    // State register
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r_reg          <= '0;
            r_reg.st       <= ST_IDLE;
            r_reg.cfg.baud <= BAUD_19200;
            r_reg.cfg.par  <= PAR_NONE;
            r_reg.cfg.mode <= MODE_NONE;
            r_reg.cfg.crc  <= 1'b1;
            r_reg.cfg.node <= NODE_DEF;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

endmodule

// ===== hdl/rmsl_pkg.sv
// Package for the radio modem serial link block.
// Assumes a 100 MHz mclk and a plain register port.
package rmsl_pkg;

    // ---------------------------------------------
    // Timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000000;
    localparam int MS_CYCLES     = TICK_NS / CLK_PERIOD_NS;
    localparam int STEP_MS       = 20;
    localparam int MSW           = 20;
    localparam int TW            = 24;

    // ---------------------------------------------
    // Register map
    // ---------------------------------------------
    localparam int AW = 4;
    localparam int DW = 16;
    localparam logic [AW-1:0] ADDR_CFG   = 4'h0;
    localparam logic [AW-1:0] ADDR_NODE  = 4'h1;
    localparam logic [AW-1:0] ADDR_POLL  = 4'h2;
    localparam logic [AW-1:0] ADDR_OFF   = 4'h3;
    localparam logic [AW-1:0] ADDR_ON    = 4'h4;
    localparam logic [AW-1:0] ADDR_PRE   = 4'h5;
    localparam logic [AW-1:0] ADDR_RETRY = 4'h6;
    localparam logic [AW-1:0] ADDR_STAT  = 4'h7;
    localparam logic [AW-1:0] ADDR_CNT0  = 4'h8;

    // Field positions in the configuration and status words
    localparam int CFG_BAUD_LSB = 0;
    localparam int CFG_PAR_LSB  = 3;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_CRC_BIT  = 7;
    localparam int CFG_DUP_BIT  = 8;
    localparam int STAT_CLR_BIT = 0;

    // Line rate codes
    localparam logic [2:0] BAUD_1200  = 3'h0;
    localparam logic [2:0] BAUD_2400  = 3'h1;
    localparam logic [2:0] BAUD_4800  = 3'h2;
    localparam logic [2:0] BAUD_9600  = 3'h3;
    localparam logic [2:0] BAUD_19200 = 3'h4;
    localparam logic [2:0] BAUD_38400 = 3'h5;

    // Parity and modem control-line modes
    localparam logic [1:0] PAR_NONE  = 2'h0;
    localparam logic [1:0] PAR_EVEN  = 2'h1;
    localparam logic [1:0] PAR_ODD   = 2'h2;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_RTS  = 2'h1;
    localparam logic [1:0] MODE_DCD  = 2'h2;

    localparam logic [7:0]    NODE_DEF   = 8'h01;
    localparam logic [7:0]    NODE_BCAST = 8'hff;
    localparam logic [DW-1:0] CNT_MAX    = 16'hffff;

    // Diagnostic counter indices
    localparam int NCNT      = 8;
    localparam int CNT_SENT  = 0;
    localparam int CNT_RECV  = 1;
    localparam int CNT_NAK   = 2;
    localparam int CNT_NOMEM = 3;
    localparam int CNT_RETRY = 4;
    localparam int CNT_UNDEL = 5;
    localparam int CNT_DUP   = 6;
    localparam int CNT_BAD   = 7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_POLL = 3'h1,
        ST_PRE  = 3'h2,
        ST_RON  = 3'h3,
        ST_SEND = 3'h4,
        ST_ROFF = 3'h5,
        ST_ACK  = 3'h6
    } rmsl_state_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          we;
        logic          re;
    } rmsl_bus_t;

    typedef struct packed {
        logic       msg_req;
        logic       msg_tmo;
        logic       poll_rx;
        logic       tx_done;
        logic       ack_rx;
        logic       nak_rx;
        logic       ack_tmo;
        logic       cts;
    } rmsl_txev_t;

    typedef struct packed {
        logic          chr_valid;
        logic [7:0]    chr;
        logic          chr_par;
        logic          frm_end;
        logic          chk_ok;
        logic [7:0]    dst;
        logic          buf_free;
        logic [DW-1:0] sig;
    } rmsl_rxev_t;

    typedef struct packed {
        logic [2:0] baud;
        logic [1:0] par;
        logic [1:0] mode;
        logic       crc;
        logic       dup;
        logic [7:0] node;
    } rmsl_cfg_t;

    typedef struct packed {
        logic rts;
        logic tx_en;
        logic msg_err;
        logic msg_ok;
        logic rx_ack;
        logic rx_exec;
    } rmsl_out_t;

    typedef struct packed {
        rmsl_state_t              st;
        logic [MSW-1:0]           ms_cnt;
        logic [TW-1:0]            tmr;
        logic [7:0]               tries;
        logic                     resend;
        logic                     par_err;
        logic                     have_sig;
        logic [DW-1:0]            last_sig;
        rmsl_cfg_t                cfg;
        logic [DW-1:0]            poll;
        logic [DW-1:0]            off;
        logic [DW-1:0]            on;
        logic [DW-1:0]            pre;
        logic [7:0]               retries;
        logic [NCNT-1:0][DW-1:0]  cnt;
        rmsl_out_t                out;
        logic [DW-1:0]            rdata;
    } rmsl_reg_t;

endpackage

// ===== sim/rmsl_link_asserts.sv
// Port checks for the serial link block.
// Assumes one mclk domain and an async active-low rst_b.
`timescale 1ns/1ps

module rmsl_link_asserts
    import rmsl_pkg::*;
#(
    parameter int MS_CYCLES_P = 10
) (
    input wire logic                  mclk,
    input wire logic                  rst_b,
    input wire logic                  ce,
    input wire rmsl_pkg::rmsl_bus_t   bus,
    input wire logic [rmsl_pkg::DW-1:0] reg_rdata,
    input wire rmsl_pkg::rmsl_txev_t  tx_ev,
    input wire rmsl_pkg::rmsl_rxev_t  rx_ev,
    input wire rmsl_pkg::rmsl_cfg_t   cfg,
    input wire rmsl_pkg::rmsl_out_t   ctl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ---------------------------------------------
    // Receive side
    // ---------------------------------------------
    chk_bad_noack: assert property (
        rx_ev.frm_end && !rx_ev.chk_ok |=> !ctl.rx_ack)
        else $error("ack given for bad frame");
    chk_good_ack: assert property (
        rx_ev.frm_end && rx_ev.chk_ok && rx_ev.buf_free &&
        rx_ev.dst == cfg.node && cfg.par == PAR_NONE |=> ctl.rx_ack)
        else $error("good frame not acked");
    chk_nomem_noack: assert property (
        rx_ev.frm_end && !rx_ev.buf_free |=> !ctl.rx_ack)
        else $error("ack given without buffer");
    chk_dup_skip: assert property (
        ctl.rx_ack && !ctl.rx_exec |-> $past(cfg.dup))
        else $error("frame skipped with detect off");

    // ---------------------------------------------
    // Transmit side and settings
    // ---------------------------------------------
    chk_txen_cts: assert property (
        ctl.tx_en && cfg.mode != MODE_NONE |->
        $past(tx_ev.cts) || $past(tx_ev.cts, 2))
        else $error("sending without clear to send");
    chk_rts_mode: assert property (
        ctl.rts |-> cfg.mode != MODE_NONE)
        else $error("rts raised with no handshake");
    chk_txen_rts: assert property (
        $rose(ctl.tx_en) && cfg.mode != MODE_NONE |-> ctl.rts)
        else $error("sending before rts");
    chk_rts_hold: assert property (
        tx_ev.tx_done && ctl.rts |=> ctl.rts)
        else $error("rts dropped at end of frame");
    chk_node_legal: assert property (
        cfg.node != NODE_BCAST)
        else $error("own address is broadcast");
    chk_cfg_stable: assert property (
        !$past(bus.we) |-> $stable(cfg))
        else $error("settings moved without write");
    chk_ok_err: assert property (
        !(ctl.msg_ok && ctl.msg_err))
        else $error("message both done and failed");
endmodule

bind rmsl_link rmsl_link_asserts #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .bus(bus), .reg_rdata(reg_rdata),
    .tx_ev(tx_ev), .rx_ev(rx_ev), .cfg(cfg), .ctl(ctl));

// ===== sim/rmsl_modem_model.sv
// Modem and master reply model for the link block.
// Assumes the bench picks the reply kind before each message.
`timescale 1ns/1ps

module rmsl_modem_model
    import rmsl_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire rmsl_pkg::rmsl_out_t ctl,
    input  wire logic [1:0]          reply,
    output logic                     cts,
    output logic                     tx_done,
    output logic                     ack_rx,
    output logic                     nak_rx,
    output logic                     ack_tmo
);
    logic [1:0] cts_dly;
    logic [2:0] chr_cnt;
    logic [1:0] gap;
    logic       pend;

    // Cts follows rts two cycles late; frame ends after four chars
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cts_dly <= 2'h0;
            chr_cnt <= 3'h0;
            gap     <= 2'h0;
            pend    <= 1'b0;
            tx_done <= 1'b0;
            ack_rx  <= 1'b0;
            nak_rx  <= 1'b0;
            ack_tmo <= 1'b0;
        end else begin
            cts_dly <= {cts_dly[0], ctl.rts};
            tx_done <= 1'b0;
            ack_rx  <= 1'b0;
            nak_rx  <= 1'b0;
            ack_tmo <= 1'b0;
            if (ctl.tx_en && !pend) begin
                chr_cnt <= chr_cnt + 3'h1;
                if (chr_cnt == 3'h3) begin
                    tx_done <= 1'b1;
                    pend    <= 1'b1;
                    chr_cnt <= 3'h0;
                end
            end
            // Reply only after the line is turned round
            if (pend && !ctl.rts && !tx_done) begin
                gap <= gap + 2'h1;
                if (gap == 2'h2) begin
                    pend    <= 1'b0;
                    gap     <= 2'h0;
                    ack_rx  <= (reply == 2'h0);
                    nak_rx  <= (reply == 2'h1);
                    ack_tmo <= (reply == 2'h2);
                end
            end
        end
    end
    assign cts = cts_dly[1];
endmodule

// ===== sim/radio_modem_serial_link_tb_top.sv
// Self-checking bench for the serial link block.
// Assumes the modem model answers each frame of the sequencer.
`timescale 1ns/1ps

module radio_modem_serial_link_tb_top;
    import rmsl_pkg::*;
    localparam int MS_P = 10;
    typedef struct {
        logic [15:0] cfg; logic chk; logic [7:0] dst; logic bf;
        logic [15:0] sig; logic par; logic ack; logic ex; int ci; logic dup;
    } rmsl_row_t;
    localparam rmsl_cfg_t DEF = {BAUD_19200, PAR_NONE, MODE_NONE,
                                 1'b1, 1'b0, NODE_DEF};
    logic                mclk, rst_b, ce, msg_req, msg_tmo, poll_rx;
    logic                cts, tx_done, ack_rx, nak_rx, ack_tmo;
    logic [1:0]          reply;
    logic [DW-1:0]       reg_rdata, rv;
    rmsl_bus_t           bus;
    rmsl_txev_t          tx_ev;
    rmsl_rxev_t          rx_ev;
    rmsl_cfg_t           cfg;
    rmsl_out_t           ctl;
    int                  bad_count, compares, n_wait, t_rts, t_tx;
    int                  exp_cnt[NCNT];
    rmsl_row_t           rows[10] = '{
        '{16'h0084, 1, 8'h01, 1, 16'h1111, 0, 1, 1, CNT_RECV, 0},
        '{16'h0084, 1, 8'h01, 1, 16'h1111, 0, 1, 1, CNT_RECV, 1},
        '{16'h0184, 1, 8'h01, 1, 16'h1111, 0, 1, 0, CNT_RECV, 1},
        '{16'h0084, 0, 8'h01, 1, 16'h5555, 0, 0, 0, CNT_BAD, 0},
        '{16'h0084, 1, 8'h05, 1, 16'h6666, 0, 0, 0, -1, 0},
        '{16'h0084, 1, 8'hff, 0, 16'h4444, 0, 0, 0, CNT_NOMEM, 0},
        '{16'h008c, 1, 8'h01, 1, 16'h2222, 0, 1, 1, CNT_RECV, 0},
        '{16'h008c, 1, 8'h01, 1, 16'h7777, 1, 0, 0, CNT_BAD, 0},
        '{16'h0094, 1, 8'hff, 1, 16'h3333, 1, 1, 1, CNT_RECV, 0},
        '{16'h0094, 1, 8'h01, 1, 16'h8888, 0, 0, 0, CNT_BAD, 0}};

    assign tx_ev = {msg_req, msg_tmo, poll_rx, tx_done, ack_rx, nak_rx,
                    ack_tmo, cts};

    rmsl_link #(.MS_CYCLES_P(MS_P)) u_rmsl_link (.mclk(mclk),
        .rst_b(rst_b), .ce(ce), .bus(bus), .reg_rdata(reg_rdata),
        .tx_ev(tx_ev), .rx_ev(rx_ev), .cfg(cfg), .ctl(ctl));
    rmsl_modem_model u_rmsl_modem_model (.mclk(mclk), .rst_b(rst_b),
        .ctl(ctl), .reply(reply), .cts(cts), .tx_done(tx_done),
        .ack_rx(ack_rx), .nak_rx(nak_rx), .ack_tmo(ack_tmo));

    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h want %h",
                     $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask
    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge mclk);
        bus <= '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1;
        check(reg_rdata, e, "read data");
    endtask
    task automatic wait_res(input int lim);
        n_wait = 0;
        t_rts = -1;
        t_tx = -1;
        while (ctl.msg_ok !== 1'b1 && ctl.msg_err !== 1'b1 && n_wait < lim) begin
            @(posedge mclk);
            #1;
            n_wait++;
            if (ctl.rts === 1'b1 && t_rts < 0)
                t_rts = n_wait;
            if (ctl.tx_en === 1'b1 && t_tx < 0)
                t_tx = n_wait;
        end
    endtask
    // Poll seen in the same cycle as the message is raised must not start it
    task automatic txn(input logic [1:0] rep, input logic e);
        @(posedge mclk);
        msg_req <= 1'b1;
        poll_rx <= 1'b1;
        reply <= rep;
        @(posedge mclk);
        poll_rx <= 1'b0;
        repeat (5) begin
            @(posedge mclk);
            #1;
            check(ctl.rts | ctl.tx_en, 0, "sent before poll");
        end
        @(posedge mclk);
        poll_rx <= 1'b1;
        @(posedge mclk);
        poll_rx <= 1'b0;
        wait_res(3000);
        check({ctl.msg_ok, ctl.msg_err}, {~e, e}, "message end");
        msg_req <= 1'b0;
    endtask
    task automatic end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ---------------------------------------------
    // Clock, watchdog and main sequence
    // ---------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #100us;
        bad_count++;
        end_sim();
    end
    initial begin
        {rst_b, msg_req, msg_tmo, poll_rx, reply} = '0;
        ce = 1'b1;
        bus = '0;
        rx_ev = '0;
        bad_count = 0;
        compares = 0;
        exp_cnt = '{default: 0};
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        check(cfg, DEF, "reset settings");
        for (int i = 0; i < 16; i++)
            rdc(i[3:0], (i == 0) ? 16'h0084 : (i == 1) ? 16'h0001 : 16'h0);
        wr(ADDR_NODE, 16'h00ff);
        rdc(ADDR_NODE, 16'h0001);
        // Frame table: chr 0x03 has even weight
        foreach (rows[i]) begin
            wr(ADDR_CFG, rows[i].cfg);
            @(posedge mclk);
            rx_ev <= {1'b1, 8'h03, rows[i].par, 1'b1, rows[i].chk,
                      rows[i].dst, rows[i].bf, rows[i].sig};
            @(posedge mclk);
            rx_ev <= '0;
            #1;
            check({ctl.rx_ack, ctl.rx_exec}, {rows[i].ack, rows[i].ex}, "rx");
            if (rows[i].ci >= 0)
                exp_cnt[rows[i].ci]++;
            if (rows[i].dup)
                exp_cnt[CNT_DUP]++;
        end
        // Plain send with pre-transmit delay, then nak retries
        wr(ADDR_CFG, 16'h0084);
        wr(ADDR_RETRY, 16'h0001);
        wr(ADDR_PRE, 16'h0002);
        txn(2'h0, 1'b0);
        check(t_tx >= 2 * MS_P && t_tx <= 2 * MS_P + 6, 1, "pre");
        check(t_rts < 0, 1, "rts idle");
        wr(ADDR_CFG, 16'h00a4);
        wr(ADDR_ON, 16'h0001);
        wr(ADDR_OFF, 16'h0001);
        txn(2'h1, 1'b1);
        check(t_rts >= 2 * MS_P && t_rts <= 2 * MS_P + 6, 1, "rts");
        check(t_tx - t_rts >= STEP_MS * MS_P, 1, "rts on");
        wr(ADDR_CFG, 16'h00c4);
        wr(ADDR_RETRY, 16'h0000);
        txn(2'h2, 1'b1);
        exp_cnt[CNT_SENT] += 4;
        exp_cnt[CNT_RETRY] += 1;
        exp_cnt[CNT_NAK] += 2;
        exp_cnt[CNT_UNDEL] += 2;
        for (int i = 0; i < NCNT; i++)
            rdc(ADDR_CNT0 + i[3:0], exp_cnt[i][15:0]);
        wr(ADDR_STAT, 16'h0001);
        for (int i = 0; i < NCNT; i++)
            rdc(ADDR_CNT0 + i[3:0], 16'h0);
        // Poll timeout of 20 ms covers the short scan of this bench
        wr(ADDR_CFG, 16'h0084);
        wr(ADDR_PRE, 16'h0000);
        wr(ADDR_POLL, 16'h0001);
        msg_req <= 1'b1;
        wait_res(400);
        check(ctl.msg_err, 1, "poll timeout");
        check(n_wait >= STEP_MS * MS_P && n_wait <= STEP_MS * MS_P + 15,
              1, "poll time");
        msg_req <= 1'b0;
        wr(ADDR_POLL, 16'h0000);
        msg_req <= 1'b1;
        wait_res(300);
        check(n_wait, 300, "timeout off");
        @(posedge mclk);
        msg_tmo <= 1'b1;
        @(posedge mclk);
        msg_tmo <= 1'b0;
        #1;
        check(ctl.msg_err, 1, "message timeout");
        msg_req <= 1'b0;
        // Reset in mid-run restores the station settings
        wr(ADDR_CFG, 16'h0135);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        check(cfg, DEF, "settings after reset");
        end_sim();
    end
endmodule
